// ===== design/image_loader_consts.svh
`ifndef IMAGE_LOADER_CONSTS_SVH
`define IMAGE_LOADER_CONSTS_SVH

// Image layout
`define MARKER_ADDR      9'h000
`define MARKER_VALUE     8'hA5
`define MAC_FIRST_ADDR   9'h001
`define MAC_LAST_ADDR    9'h006
`define FS_INTERVAL_ADDR 9'h007
`define HS_INTERVAL_ADDR 9'h008
`define CFG_FLAGS_ADDR   9'h009
`define LANG_LO_ADDR     9'h00A
`define LANG_HI_ADDR     9'h00B
`define PTR_FIRST_ADDR   9'h00C
`define PTR_LAST_ADDR    9'h01D
`define WAKE_LO_ADDR     9'h01E
`define WAKE_HI_ADDR     9'h01F
`define PME_FLAGS_ADDR   9'h020
`define PAD_ADDR         9'h021
`define LANG_LEN         8'h02

// Built-in defaults
`define MAC_DEFAULT      48'hFFFF_FFFF_FFFF
`define FS_INT_DEFAULT   8'h01
`define HS_INT_DEFAULT   8'h04
`define CFG_FLAGS_DEFAULT 8'h04
`define WAKE_DEFAULT     11'h000
`define PME_DEFAULT      8'h00
`define LANG_DEFAULT     16'h0000

// Config flag fields
`define FLAG_SELF_POWER_BIT 1
`define FLAG_REMOTE_WAKE_BIT 2

// Register offsets and bit positions
`define REG_CTRL         4'h0
`define REG_STATUS       4'h1
`define REG_MAC_LO       4'h2
`define REG_MAC_HI       4'h3
`define REG_INTERVALS    4'h4
`define REG_WAKE         4'h5
`define CTRL_RELOAD_BIT  0
`define STAT_BUSY_BIT    0
`define STAT_LOADED_BIT  1
`define STAT_ABSENT_BIT  2

`endif

// ===== design/image_loader_pkg.sv
package image_loader_pkg;

    typedef enum logic [2:0] {
        LOAD_IDLE   = 3'b000,
        LOAD_MARKER = 3'b001,
        LOAD_COPY   = 3'b010,
        LOAD_DONE   = 3'b011,
        LOAD_ABSENT = 3'b100
    } load_state_type;

    // Descriptor kinds; 0..8 follow the pointer pairs in image order
    typedef enum logic [3:0] {
        DESC_MANUFACTURER = 4'h0,
        DESC_PRODUCT      = 4'h1,
        DESC_SERIAL       = 4'h2,
        DESC_CONFIG_STR   = 4'h3,
        DESC_IFACE_STR    = 4'h4,
        DESC_HS_DEVICE    = 4'h5,
        DESC_HS_CONFIG    = 4'h6,
        DESC_FS_DEVICE    = 4'h7,
        DESC_FS_CONFIG    = 4'h8,
        DESC_LANGUAGE     = 4'h9
    } desc_kind_type;

endpackage : image_loader_pkg

// ===== design/image_store.sv
module image_store #(
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // Write port from loader
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // Read port, data one cycle after rd_en
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data_q
);

    // No reset on the array so it maps onto plain RAM
    logic [7:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_q <= 8'h00;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule : image_store

// ===== design/descriptor_reader.sv
module descriptor_reader #(
    parameter int AW = 9
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // Transfer request
    input  wire logic          start,
    input  wire logic [AW-1:0] start_addr,
    input  wire logic [7:0]    count,
    // Store read port
    output logic               rd_en,
    output logic      [AW-1:0] rd_addr,
    // Store data valid this cycle
    output logic               byte_valid_q,
    output logic               byte_last_q,
    output logic               busy
);

    logic          active_q;
    logic [AW-1:0] addr_q;
    logic [7:0]    left_q;

    assign rd_en   = active_q;
    assign rd_addr = addr_q;
    assign busy    = active_q | byte_valid_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            active_q <= 1'b0;
            addr_q   <= '0;
            left_q   <= 8'h00;
        end else if (start && !active_q) begin
            active_q <= (count != 8'h00);
            addr_q   <= start_addr;
            left_q   <= count;
        end else if (active_q) begin
            addr_q   <= addr_q + 1'b1;
            left_q   <= left_q - 8'h01;
            active_q <= (left_q != 8'h01);
        end
    end

    // Store answers one cycle after the address
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            byte_valid_q <= 1'b0;
            byte_last_q  <= 1'b0;
        end else begin
            byte_valid_q <= active_q;
            byte_last_q  <= active_q && (left_q == 8'h01);
        end
    end

endmodule : descriptor_reader

// ===== design/image_loader.sv
// Functional notes
// - Load only when byte zero equals A5h
// - No marker: stop, keep built-in defaults
// - Marker present: copy image into 512-byte store
// - Bytes 1 to 6 form MAC, ascending
// - Byte 07h: full-speed interrupt polling interval
// - Byte 08h: high-speed interrupt polling interval
// - Byte 09h: power, wakeup, LED function flags
// - Bytes 0Ah/0Bh: language ID, low first
// - String pointers: length then word offset
// - Word offset times two gives byte address
// - Zero length means descriptor not provided
// - 16h..19h: high-speed device and config pointers
// - 1Ah..1Dh: full-speed device and config pointers
// - 1Eh/1Fh: wake enables for pins 10..0
// - Byte 20h: wake event signalling flags
// - Byte 21h is padding, ignored
// - String descriptors served byte for byte unchanged
//
// Strobed register access and the register offsets were decided locally.
`include "image_loader_consts.svh"

module image_loader
    import image_loader_pkg::*;
#(
    parameter int IMAGE_BYTES = 512,
    parameter int AW          = 9
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // Register port
    input  wire logic [3:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [31:0]   reg_rdata_q,
    // Byte read port of the serial memory controller
    output logic               ee_rd_req_q,
    output logic      [AW-1:0] ee_addr_q,
    input  wire logic          ee_rd_valid,
    input  wire logic [7:0]    ee_rd_data,
    // Loaded configuration
    output logic               load_busy_q,
    output logic               load_done_q,
    output logic               marker_ok_q,
    output logic      [47:0]   mac_addr_q,
    output logic      [7:0]    fs_interval_q,
    output logic      [7:0]    hs_interval_q,
    output logic      [7:0]    cfg_flags_q,
    output logic               self_powered_q,
    output logic               remote_wake_q,
    output logic      [15:0]   lang_id_q,
    output logic      [10:0]   gpio_wake_en_q,
    output logic      [7:0]    pme_flags_q,
    // Descriptor fetch from the control logic
    input  wire logic          desc_req,
    input  wire logic [3:0]    desc_kind,
    input  wire logic [7:0]    desc_req_len,
    output logic               desc_valid_q,
    output logic      [7:0]    desc_data_q,
    output logic               desc_last_q,
    output logic               desc_none_q
);

    function automatic logic [AW-1:0] word_to_byte(input logic [7:0] word_off);
        word_to_byte = {word_off, 1'b0};
    endfunction : word_to_byte

    function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
        min8 = (a < b) ? a : b;
    endfunction : min8

    localparam logic [AW-1:0] LAST_ADDR = AW'(IMAGE_BYTES - 1);

    load_state_type state_q;
    logic           start_pending_q;
    logic           accept;
    logic           reload_wr;
    logic [7:0]     ptr_len_q [9];
    logic [7:0]     ptr_off_q [9];
    logic [3:0]     ptr_idx;
    logic           rd_en;
    logic [AW-1:0]  rd_addr;
    logic [7:0]     store_data;
    logic           rdr_valid;
    logic           rdr_last;
    logic           rdr_busy;
    logic           rdr_start;
    logic [AW-1:0]  rdr_addr;
    logic [7:0]     rdr_count;
    logic [7:0]     sel_len;
    logic [AW-1:0]  sel_addr;

    assign reload_wr = reg_wr && (reg_addr == `REG_CTRL) && reg_wdata[`CTRL_RELOAD_BIT];
    // Only bytes of a marked image reach the store and fields
    assign accept = ee_rd_valid && ((state_q == LOAD_COPY)
                 || (state_q == LOAD_MARKER && ee_rd_data == `MARKER_VALUE));
    assign ptr_idx = 4'(ee_addr_q[4:1] - 4'h6);

    // Load sequencing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q         <= LOAD_IDLE;
            start_pending_q <= 1'b1;
            ee_rd_req_q     <= 1'b0;
            ee_addr_q       <= '0;
        end else begin
            ee_rd_req_q <= 1'b0;
            if (reload_wr) begin
                start_pending_q <= 1'b1;
            end
            case (state_q)
                LOAD_IDLE, LOAD_DONE, LOAD_ABSENT: begin
                    if (start_pending_q && !rdr_busy) begin
                        start_pending_q <= reload_wr;
                        ee_addr_q       <= `MARKER_ADDR;
                        ee_rd_req_q     <= 1'b1;
                        state_q         <= LOAD_MARKER;
                    end
                end
                LOAD_MARKER: begin
                    if (ee_rd_valid) begin
                        if (ee_rd_data == `MARKER_VALUE) begin
                            ee_addr_q   <= `MAC_FIRST_ADDR;
                            ee_rd_req_q <= 1'b1;
                            state_q     <= LOAD_COPY;
                        end else begin
                            state_q <= LOAD_ABSENT;
                        end
                    end
                end
                LOAD_COPY: begin
                    if (ee_rd_valid) begin
                        if (ee_addr_q == LAST_ADDR) begin
                            state_q <= LOAD_DONE;
                        end else begin
                            ee_addr_q   <= ee_addr_q + 1'b1;
                            ee_rd_req_q <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_q <= LOAD_IDLE;
                end
            endcase
        end
    end

    // Status flags
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            load_busy_q <= 1'b1;
            load_done_q <= 1'b0;
            marker_ok_q <= 1'b0;
        end else begin
            load_busy_q <= start_pending_q || state_q == LOAD_MARKER || state_q == LOAD_COPY;
            load_done_q <= (state_q == LOAD_DONE);
            marker_ok_q <= (state_q == LOAD_COPY) || (state_q == LOAD_DONE);
        end
    end

    // Fields go back to defaults at each load start, so an absent marker leaves them there
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mac_addr_q     <= `MAC_DEFAULT;
            fs_interval_q  <= `FS_INT_DEFAULT;
            hs_interval_q  <= `HS_INT_DEFAULT;
            cfg_flags_q    <= `CFG_FLAGS_DEFAULT;
            lang_id_q      <= `LANG_DEFAULT;
            gpio_wake_en_q <= `WAKE_DEFAULT;
            pme_flags_q    <= `PME_DEFAULT;
        end else if (state_q != LOAD_MARKER && state_q != LOAD_COPY && start_pending_q
                     && !rdr_busy) begin
            mac_addr_q     <= `MAC_DEFAULT;
            fs_interval_q  <= `FS_INT_DEFAULT;
            hs_interval_q  <= `HS_INT_DEFAULT;
            cfg_flags_q    <= `CFG_FLAGS_DEFAULT;
            lang_id_q      <= `LANG_DEFAULT;
            gpio_wake_en_q <= `WAKE_DEFAULT;
            pme_flags_q    <= `PME_DEFAULT;
        end else if (accept && state_q == LOAD_COPY) begin
            if (ee_addr_q >= `MAC_FIRST_ADDR && ee_addr_q <= `MAC_LAST_ADDR) begin
                mac_addr_q <= {mac_addr_q[39:0], ee_rd_data};
            end
            case (ee_addr_q)
                `FS_INTERVAL_ADDR: fs_interval_q <= ee_rd_data;
                `HS_INTERVAL_ADDR: hs_interval_q <= ee_rd_data;
                `CFG_FLAGS_ADDR:   cfg_flags_q <= ee_rd_data;
                `LANG_LO_ADDR:     lang_id_q[7:0] <= ee_rd_data;
                `LANG_HI_ADDR:     lang_id_q[15:8] <= ee_rd_data;
                `WAKE_LO_ADDR:     gpio_wake_en_q[7:0] <= ee_rd_data;
                `WAKE_HI_ADDR:     gpio_wake_en_q[10:8] <= ee_rd_data[2:0];
                `PME_FLAGS_ADDR:   pme_flags_q <= ee_rd_data;
                default: begin
                    // Pad byte and descriptor bodies live only in the store
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            self_powered_q <= 1'b0;
            remote_wake_q  <= 1'b0;
        end else begin
            self_powered_q <= cfg_flags_q[`FLAG_SELF_POWER_BIT];
            remote_wake_q  <= cfg_flags_q[`FLAG_REMOTE_WAKE_BIT];
        end
    end

    // Pointer pairs: even byte is length, odd byte is word offset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 9; i++) begin
                ptr_len_q[i] <= 8'h00;
                ptr_off_q[i] <= 8'h00;
            end
        end else if (state_q == LOAD_MARKER && ee_rd_valid) begin
            for (int i = 0; i < 9; i++) begin
                ptr_len_q[i] <= 8'h00;
            end
        end else if (accept && state_q == LOAD_COPY && ee_addr_q >= `PTR_FIRST_ADDR
                     && ee_addr_q <= `PTR_LAST_ADDR) begin
            if (!ee_addr_q[0]) begin
                ptr_len_q[ptr_idx] <= ee_rd_data;
            end else begin
                ptr_off_q[ptr_idx] <= ee_rd_data;
            end
        end
    end

    // Descriptor selection
    always_comb begin
        sel_len  = 8'h00;
        sel_addr = '0;
        if (desc_kind == DESC_LANGUAGE) begin
            sel_len  = `LANG_LEN;
            sel_addr = `LANG_LO_ADDR;
        end else if (desc_kind <= DESC_FS_CONFIG) begin
            sel_len  = ptr_len_q[desc_kind];
            sel_addr = word_to_byte(ptr_off_q[desc_kind]);
        end
    end

    // Zero stored length, no image, or empty request yields no data
    assign rdr_start = desc_req && !rdr_busy && !load_busy_q && marker_ok_q
                    && sel_len != 8'h00 && desc_req_len != 8'h00;
    assign rdr_addr  = sel_addr;
    assign rdr_count = min8(sel_len, desc_req_len);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            desc_none_q <= 1'b0;
        end else begin
            desc_none_q <= desc_req && !rdr_busy && !rdr_start;
        end
    end

    // Bytes leave exactly as stored
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            desc_valid_q <= 1'b0;
            desc_data_q  <= 8'h00;
            desc_last_q  <= 1'b0;
        end else begin
            desc_valid_q <= rdr_valid;
            desc_data_q  <= rdr_valid ? store_data : 8'h00;
            desc_last_q  <= rdr_last;
        end
    end

    image_store #(
        .DEPTH (IMAGE_BYTES),
        .AW    (AW)
    ) u_store (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .wr_en     (accept),
        .wr_addr   (ee_addr_q),
        .wr_data   (ee_rd_data),
        .rd_en     (rd_en),
        .rd_addr   (rd_addr),
        .rd_data_q (store_data)
    );

    descriptor_reader #(
        .AW (AW)
    ) u_reader (
        .core_clk     (core_clk),
        .resetn       (resetn),
        .start        (rdr_start),
        .start_addr   (rdr_addr),
        .count        (rdr_count),
        .rd_en        (rd_en),
        .rd_addr      (rd_addr),
        .byte_valid_q (rdr_valid),
        .byte_last_q  (rdr_last),
        .busy         (rdr_busy)
    );

    // Register read, data one cycle after the strobe
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_STATUS:    reg_rdata_q <= {29'h0, !marker_ok_q && !load_busy_q,
                                                load_done_q, load_busy_q};
                `REG_MAC_LO:    reg_rdata_q <= mac_addr_q[31:0];
                `REG_MAC_HI:    reg_rdata_q <= {16'h0000, mac_addr_q[47:32]};
                `REG_INTERVALS: reg_rdata_q <= {pme_flags_q, cfg_flags_q,
                                                hs_interval_q, fs_interval_q};
                `REG_WAKE:      reg_rdata_q <= {lang_id_q, 5'h00, gpio_wake_en_q};
                default:        reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

endmodule : image_loader

// ===== test/image_loader_checker.sv
`include "image_loader_consts.svh"

module image_loader_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // Memory byte port
    input wire logic        ee_rd_req_q,
    input wire logic [8:0]  ee_addr_q,
    input wire logic        ee_rd_valid,
    input wire logic [7:0]  ee_rd_data,
    // Loaded fields
    input wire logic        load_busy_q,
    input wire logic        load_done_q,
    input wire logic        marker_ok_q,
    input wire logic [47:0] mac_addr_q,
    input wire logic [7:0]  fs_interval_q,
    input wire logic [7:0]  hs_interval_q,
    input wire logic [7:0]  cfg_flags_q,
    input wire logic        self_powered_q,
    input wire logic        remote_wake_q,
    input wire logic [15:0] lang_id_q,
    input wire logic [10:0] gpio_wake_en_q,
    input wire logic [7:0]  pme_flags_q,
    // Descriptor port
    input wire logic        desc_req,
    input wire logic        desc_valid_q,
    input wire logic        desc_last_q,
    input wire logic        desc_none_q
);
    logic [7:0] img_q [0:33];

    // Header shadow
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 34; i++) img_q[i] <= 8'h00;
        end else if (ee_rd_valid && load_busy_q && ee_addr_q < 9'h022) begin
            img_q[ee_addr_q[5:0]] <= ee_rd_data;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    chk_req_single: assert property (ee_rd_req_q |=> !ee_rd_req_q)
        else $error("request too long");
    chk_addr_hold: assert property (!ee_rd_req_q |-> $stable(ee_addr_q))
        else $error("address moved");
    chk_no_marker: assert property (ee_rd_valid && load_busy_q && ee_addr_q == `MARKER_ADDR
        && ee_rd_data != `MARKER_VALUE |=> (!ee_rd_req_q && !marker_ok_q) [*4])
        else $error("load without marker");
    chk_next_byte: assert property (ee_rd_valid && load_busy_q && ee_addr_q != 9'h1FF
        && (ee_addr_q != 9'h000 || ee_rd_data == `MARKER_VALUE)
        |=> ee_rd_req_q && ee_addr_q == $past(ee_addr_q) + 9'h001)
        else $error("next byte not asked");
    chk_load_end: assert property (ee_rd_valid && load_busy_q && ee_addr_q == 9'h1FF
        |-> ##[1:3] (load_done_q && !load_busy_q))
        else $error("load not finished");
    chk_mac_order: assert property ($rose(load_done_q) |-> mac_addr_q ==
        {img_q[1], img_q[2], img_q[3], img_q[4], img_q[5], img_q[6]})
        else $error("station address");
    chk_intervals: assert property ($rose(load_done_q) |->
        fs_interval_q == img_q[7] && hs_interval_q == img_q[8])
        else $error("intervals");
    chk_cfg_flags: assert property ($rose(load_done_q) |-> cfg_flags_q == img_q[9]
        && self_powered_q == img_q[9][`FLAG_SELF_POWER_BIT]
        && remote_wake_q == img_q[9][`FLAG_REMOTE_WAKE_BIT])
        else $error("config flags");
    chk_lang_wake: assert property ($rose(load_done_q) |->
        lang_id_q == {img_q[11], img_q[10]} && gpio_wake_en_q == {img_q[31][2:0], img_q[30]})
        else $error("lang or wake");
    chk_pme_flags: assert property ($rose(load_done_q) |-> pme_flags_q == img_q[32])
        else $error("wake flags");
    chk_defaults: assert property ($fell(load_busy_q) && !marker_ok_q |->
        mac_addr_q == `MAC_DEFAULT && fs_interval_q == `FS_INT_DEFAULT
        && hs_interval_q == `HS_INT_DEFAULT && cfg_flags_q == `CFG_FLAGS_DEFAULT
        && gpio_wake_en_q == `WAKE_DEFAULT && pme_flags_q == `PME_DEFAULT)
        else $error("defaults lost");
    chk_busy_refuse: assert property (desc_req && load_busy_q |=> desc_none_q)
        else $error("served during load");
    chk_last_valid: assert property (desc_last_q |-> desc_valid_q)
        else $error("last without byte");

    cover property ($rose(load_done_q));
    cover property (desc_valid_q && desc_last_q);
    cover property ($fell(load_busy_q) && !marker_ok_q);
endmodule : image_loader_checker

// ===== test/ee_image_model.sv
module ee_image_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Answer pace
    input  wire logic       slow,
    // Byte port
    input  wire logic       ee_rd_req_q,
    input  wire logic [8:0] ee_addr_q,
    output logic            ee_rd_valid,
    output logic [7:0]      ee_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:511];
    logic       pend_q;
    logic [8:0] addr_q;
    int         wait_q;

    // Inverted off valid
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            ee_rd_valid <= 1'b0;
            ee_rd_data <= 8'h00;
        end else begin
            ee_rd_valid <= 1'b0;
            ee_rd_data <= ~ee_rd_data;
            if (ee_rd_req_q) begin
                pend_q <= 1'b1;
                addr_q <= ee_addr_q;
                wait_q <= slow ? $urandom_range(12) : 0;
            end else if (pend_q && wait_q > 0) begin
                wait_q <= wait_q - 1;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                ee_rd_valid <= 1'b1;
                ee_rd_data <= mem[addr_q];
            end
        end
    end
endmodule : ee_image_model

// ===== test/tb_image_loader.sv
`include "image_loader_consts.svh"
`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end

module tb_image_loader
    import image_loader_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk, resetn, reg_wr, reg_rd, ee_rd_req_q, ee_rd_valid, slow;
    logic        desc_req, desc_valid_q, desc_last_q, desc_none_q, rd_d1, ok;
    logic [3:0]  reg_addr, desc_kind;
    logic [31:0] reg_wdata, reg_rdata_q;
    logic [8:0]  ee_addr_q;
    logic [7:0]  ee_rd_data, desc_len, desc_data_q;
    logic [33:0] got, exp_q [$];
    logic [7:0]  img [0:511];
    int          errors, cmp_count, cycles;

    image_loader u_image_loader (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .ee_rd_req_q(ee_rd_req_q), .ee_addr_q(ee_addr_q), .ee_rd_valid(ee_rd_valid),
        .ee_rd_data(ee_rd_data), .load_busy_q(), .load_done_q(), .marker_ok_q(),
        .mac_addr_q(), .fs_interval_q(), .hs_interval_q(), .cfg_flags_q(), .self_powered_q(),
        .remote_wake_q(), .lang_id_q(), .gpio_wake_en_q(), .pme_flags_q(),
        .desc_req(desc_req), .desc_kind(desc_kind), .desc_req_len(desc_len),
        .desc_valid_q(desc_valid_q), .desc_data_q(desc_data_q), .desc_last_q(desc_last_q),
        .desc_none_q(desc_none_q));

    ee_image_model u_ee_image_model (.core_clk(core_clk), .resetn(resetn), .slow(slow),
        .ee_rd_req_q(ee_rd_req_q), .ee_addr_q(ee_addr_q), .ee_rd_valid(ee_rd_valid),
        .ee_rd_data(ee_rd_data));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Scoreboard
    always @(posedge core_clk) begin
        if (rd_d1 || desc_valid_q || desc_none_q) begin
            got = rd_d1 ? {2'd0, reg_rdata_q} : desc_none_q ? {2'd2, 32'h0}
                : {2'd1, 23'h0, desc_last_q, desc_data_q};
            if (exp_q.size() == 0) `CHECK(got, 34'h3_0000_0000)
            else `CHECK(got, exp_q.pop_front())
        end
        rd_d1 <= reg_rd;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back({2'd0, e});
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask : reg_read

    task automatic desc_fetch(input logic [3:0] k, input logic [7:0] n);
        int a, l;
        a = (k == DESC_LANGUAGE) ? 10 : 2 * img[13 + 2 * k];
        l = (k == DESC_LANGUAGE) ? 2 : img[12 + 2 * k];
        if (!ok || l == 0 || n == 0) exp_q.push_back({2'd2, 32'h0});
        else for (int i = 0; i < l && i < n; i++)
            exp_q.push_back({2'd1, 23'h0, 1'(i == l - 1 || i == n - 1), img[a + i]});
        desc_kind <= k;
        desc_len <= n;
        desc_req <= 1'b1;
        @(posedge core_clk);
        desc_req <= 1'b0;
        for (int c = 0; c < 400 && exp_q.size() > 0; c++) @(posedge core_clk);
        repeat (3) @(posedge core_clk);
    endtask : desc_fetch

    // Strings 3 and 4 absent
    task automatic load_image(input bit hard, input logic [7:0] m);
        for (int i = 0; i < 512; i++) img[i] = 8'($urandom);
        img[0] = m;
        img[18] = 8'h00;
        img[20] = 8'h00;
        for (int k = 0; k < 9; k++) if (k != 3 && k != 4) begin
            img[12 + 2 * k] = 8'(1 + $urandom_range(40));
            img[13 + 2 * k] = 8'(17 + $urandom_range(190));
        end
        for (int i = 0; i < 512; i++) u_ee_image_model.mem[i] = img[i];
        ok = 1'b0;
        if (hard) begin
            resetn <= 1'b0;
            repeat (6) @(posedge core_clk);
            resetn <= 1'b1;
        end else reg_write(`REG_CTRL, 32'h1);
        @(posedge core_clk);
        desc_fetch(DESC_MANUFACTURER, 8'h10);
        for (int c = 0; c < 9000 && u_image_loader.load_busy_q !== 1'b0; c++) @(posedge core_clk);
        ok = (m == `MARKER_VALUE);
    endtask : load_image

    task automatic check_regs();
        logic [47:0] mac;
        logic [31:0] iv, wk;
        mac = ok ? {img[1], img[2], img[3], img[4], img[5], img[6]} : `MAC_DEFAULT;
        iv = ok ? {img[32], img[9], img[8], img[7]}
            : {`PME_DEFAULT, `CFG_FLAGS_DEFAULT, `HS_INT_DEFAULT, `FS_INT_DEFAULT};
        wk = ok ? {img[11], img[10], 5'h00, img[31][2:0], img[30]} : 32'h0;
        reg_write(`REG_MAC_LO, 32'($urandom));
        reg_read(`REG_STATUS, ok ? 32'h2 : 32'h4);
        reg_read(`REG_MAC_LO, mac[31:0]);
        reg_read(`REG_MAC_HI, {16'h0, mac[47:32]});
        reg_read(`REG_INTERVALS, iv);
        reg_read(`REG_WAKE, wk);
        reg_read(`REG_CTRL, 32'h0);
        reg_read(4'hF, 32'h0);
    endtask : check_regs

    task automatic all_descs();
        for (int k = 0; k < 10; k++) desc_fetch(4'(k), 8'(1 + $urandom_range(50)));
        desc_fetch(DESC_SERIAL, img[8'h10]);
        desc_fetch(DESC_PRODUCT, 8'h00);
        desc_fetch(DESC_CONFIG_STR, 8'hFF);
    endtask : all_descs

    initial begin
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        desc_req = 1'b0;
        desc_kind = 4'h0;
        desc_len = 8'h00;
        rd_d1 = 1'b0;
        void'($urandom(35033));
        @(posedge core_clk);
        for (int t = 1; t <= 3; t++) begin
            slow <= (t == 2);
            load_image(t != 2, (t == 3) ? 8'h5A : `MARKER_VALUE);
            check_regs();
            all_descs();
            $display("test %0d done", t);
        end
        tally_and_finish();
    end
endmodule : tb_image_loader

bind image_loader image_loader_checker u_image_loader_checker (.*);
